// ==== verilog/gtm_map.svh ====
// Register offsets, field positions and sizing constants for the gated timer block
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH

// ****************************************************************
// Register map, one aligned word each, 0x20 bytes per timer
// ****************************************************************
`define GTM_STRIDE 8'h20
`define GTM_OFF_RUN 8'h00
`define GTM_OFF_GCTL 8'h04
`define GTM_OFF_CNTL 8'h08
`define GTM_OFF_CNTH 8'h0c
`define GTM_OFF_FLAGS 8'h10

// ****************************************************************
// Gate control and flag field positions
// ****************************************************************
`define GTM_GE_BIT 7
`define GTM_GPOL_BIT 6
`define GTM_GTM_BIT 5
`define GTM_GSPM_BIT 4
`define GTM_GGO_BIT 3
`define GTM_GVAL_BIT 2
`define GTM_FLAG_ROLL_BIT 0
`define GTM_FLAG_GATE_BIT 1

// ****************************************************************
// Source select codes and counts
// ****************************************************************
`define GTM_SRC_PIN 2'b00
`define GTM_SRC_T0 2'b01
`define GTM_SRC_CMP1 2'b10
`define GTM_SRC_CMP2 2'b11
`define GTM_NUM_TIMERS 3
`define GTM_COUNT_MAX 16'hffff

`endif

// ==== verilog/gtm_pkg.sv ====
// Types shared by the gated timer block
package gtm_pkg;

  // Per-timer software configuration
  typedef struct packed {
    logic run;
    logic gate_en;
    logic gate_pol;
    logic toggle_en;
    logic spm_en;
    logic [1:0] src_sel;
  } gtm_cfg_t;

  // Per-timer gate sources
  typedef struct packed {
    logic pin;
    logic t0_ovf;
    logic cmp1;
    logic cmp2;
    logic cmp1_sync_en;
    logic cmp2_sync_en;
  } gtm_src_t;

  // Per-timer live state
  typedef struct packed {
    gtm_cfg_t cfg;
    logic arm;
    logic tog_ff;
    logic gate_val;
    logic spm_open;
    logic [15:0] count;
    logic roll_flag;
    logic gate_flag;
    logic cmp1_s;
    logic cmp2_s;
    logic src_prev;
  } gtm_tmr_t;

  // Bus-side state of the whole block
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gtm_bus_t;

endpackage

// ==== verilog/gtm_timers.sv ====
// Three gated 16-bit timers with gate control, count bytes and event flags behind an APB slave
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "gtm_map.svh"

module gtm_timers #(
  parameter int NUM_TIMERS = `GTM_NUM_TIMERS
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Gate sources, one set per timer
  input wire gtm_pkg::gtm_src_t [NUM_TIMERS-1:0] gate_src,
  // Event flags, one pair per timer
  output logic [NUM_TIMERS-1:0] rollover_flag,
  output logic [NUM_TIMERS-1:0] gate_event_flag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    gtm_pkg::gtm_tmr_t [NUM_TIMERS-1:0] tmr;
    gtm_pkg::gtm_bus_t bus;
  } gtm_state_t;

  gtm_state_t state_reg;
  gtm_state_t state_next;

  // Gate control register image; status bits always reflect hardware
  function automatic logic [7:0] gctl_image(input gtm_pkg::gtm_tmr_t t);
    gctl_image = {t.cfg.gate_en, t.cfg.gate_pol, t.cfg.toggle_en, t.cfg.spm_en,
                  t.arm, t.gate_val, t.cfg.src_sel};
  endfunction

  // Gate source mux with optional comparator synchronisation
  function automatic logic pick_src(input gtm_pkg::gtm_tmr_t t, input gtm_pkg::gtm_src_t s);
    logic c1;
    logic c2;
    c1 = s.cmp1_sync_en ? t.cmp1_s : s.cmp1;
    c2 = s.cmp2_sync_en ? t.cmp2_s : s.cmp2;
    unique case (t.cfg.src_sel)
      `GTM_SRC_PIN: pick_src = s.pin;
      `GTM_SRC_T0: pick_src = s.t0_ovf;
      `GTM_SRC_CMP1: pick_src = c1;
      `GTM_SRC_CMP2: pick_src = c2;
    endcase
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // One pass fills every timer; bus writes are applied last so a
  // byte write beats the increment in the same cycle.
  always_comb begin
    logic wr;
    logic rd;
    logic [2:0] idx;
    logic [7:0] off;
    logic hit;
    logic src;
    logic pol;
    logic rise;
    logic gval;
    logic gate_ok;
    logic inc;
    wr = 1'b0;
    rd = 1'b0;
    idx = 3'h0;
    off = 8'h00;
    hit = 1'b0;
    src = 1'b0;
    pol = 1'b0;
    rise = 1'b0;
    gval = 1'b0;
    gate_ok = 1'b0;
    inc = 1'b0;
    state_next = state_reg;
    state_next.bus.pready = 1'b0;
    state_next.bus.pslverr = 1'b0;
    wr = psel && !penable && pwrite;
    rd = psel && !penable && !pwrite;
    idx = paddr[7:5];
    off = {3'h0, paddr[4:0]};
    hit = (int'(idx) < NUM_TIMERS) && (paddr[1:0] == 2'b00) && (off <= `GTM_OFF_FLAGS);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      // Comparator synchroniser stage
      state_next.tmr[i].cmp1_s = gate_src[i].cmp1;
      state_next.tmr[i].cmp2_s = gate_src[i].cmp2;
      src = pick_src(state_reg.tmr[i], gate_src[i]);
      state_next.tmr[i].src_prev = src;
      rise = src && !state_reg.tmr[i].src_prev;
      pol = state_reg.tmr[i].cfg.gate_pol ? src : !src;
      // Toggle flip-flop, held clear when disabled or timer off
      if (!state_reg.tmr[i].cfg.toggle_en || !state_reg.tmr[i].cfg.run) begin
        state_next.tmr[i].tog_ff = 1'b0;
      end else if (rise) begin
        state_next.tmr[i].tog_ff = !state_reg.tmr[i].tog_ff;
      end
      gval = state_reg.tmr[i].cfg.toggle_en ? state_reg.tmr[i].tog_ff : pol;
      // Single pulse: open on active edge while armed, close on trailing edge
      if (state_reg.tmr[i].cfg.spm_en) begin
        if (state_reg.tmr[i].arm && !state_reg.tmr[i].spm_open && gval && !state_reg.tmr[i].gate_val) begin
          state_next.tmr[i].spm_open = 1'b1;
        end else if (state_reg.tmr[i].spm_open && !gval && state_reg.tmr[i].gate_val) begin
          state_next.tmr[i].spm_open = 1'b0;
          state_next.tmr[i].arm = 1'b0;
        end
        gval = gval && (state_reg.tmr[i].spm_open || (state_reg.tmr[i].arm && !state_reg.tmr[i].gate_val));
      end else begin
        state_next.tmr[i].spm_open = 1'b0;
        state_next.tmr[i].arm = 1'b0;
      end
      state_next.tmr[i].gate_val = gval;
      if (state_reg.tmr[i].gate_val && !gval) begin
        state_next.tmr[i].gate_flag = 1'b1;
      end
      gate_ok = !state_reg.tmr[i].cfg.gate_en || state_reg.tmr[i].gate_val;
      inc = state_reg.tmr[i].cfg.run && gate_ok;
      if (inc) begin
        state_next.tmr[i].count = state_reg.tmr[i].count + 16'h0001;
        if (state_reg.tmr[i].count == `GTM_COUNT_MAX) begin
          state_next.tmr[i].roll_flag = 1'b1;
        end
      end
    end
    // Register access during the setup cycle; answer in the access cycle
    if (psel && !penable) begin
      state_next.bus.pready = 1'b1;
      state_next.bus.pslverr = !hit;
      state_next.bus.prdata = 32'h0000_0000;
    end
    if (rd && hit) begin
      unique case (off)
        `GTM_OFF_RUN: state_next.bus.prdata = {31'h0, state_reg.tmr[idx].cfg.run};
        `GTM_OFF_GCTL: state_next.bus.prdata = {24'h0, gctl_image(state_reg.tmr[idx])};
        `GTM_OFF_CNTL: state_next.bus.prdata = {24'h0, state_reg.tmr[idx].count[7:0]};
        `GTM_OFF_CNTH: state_next.bus.prdata = {24'h0, state_reg.tmr[idx].count[15:8]};
        `GTM_OFF_FLAGS: state_next.bus.prdata = {30'h0, state_reg.tmr[idx].gate_flag, state_reg.tmr[idx].roll_flag};
        default: state_next.bus.prdata = 32'h0000_0000;
      endcase
    end
    if (wr && hit) begin
      unique case (off)
        `GTM_OFF_RUN: state_next.tmr[idx].cfg.run = pwdata[0];
        `GTM_OFF_GCTL: begin
          state_next.tmr[idx].cfg.gate_en = pwdata[`GTM_GE_BIT];
          state_next.tmr[idx].cfg.gate_pol = pwdata[`GTM_GPOL_BIT];
          state_next.tmr[idx].cfg.toggle_en = pwdata[`GTM_GTM_BIT];
          state_next.tmr[idx].cfg.spm_en = pwdata[`GTM_GSPM_BIT];
          state_next.tmr[idx].cfg.src_sel = pwdata[1:0];
          // Arm only with single-pulse on; status bit write ignored
          if (pwdata[`GTM_GGO_BIT] && pwdata[`GTM_GSPM_BIT]) begin
            state_next.tmr[idx].arm = 1'b1;
          end else if (!pwdata[`GTM_GSPM_BIT]) begin
            state_next.tmr[idx].arm = 1'b0;
          end
        end
        `GTM_OFF_CNTL: state_next.tmr[idx].count[7:0] = pwdata[7:0];
        `GTM_OFF_CNTH: state_next.tmr[idx].count[15:8] = pwdata[7:0];
        `GTM_OFF_FLAGS: begin
          // Write one to clear; a same-cycle set event wins even if the flag was already up
          if (pwdata[`GTM_FLAG_ROLL_BIT] && !(state_reg.tmr[idx].count == `GTM_COUNT_MAX
              && state_next.tmr[idx].count == 16'h0000)) begin
            state_next.tmr[idx].roll_flag = 1'b0;
          end
          if (pwdata[`GTM_FLAG_GATE_BIT] && !(state_reg.tmr[idx].gate_val && !state_next.tmr[idx].gate_val)) begin
            state_next.tmr[idx].gate_flag = 1'b0;
          end
        end
        default: state_next.bus.pslverr = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Count bytes are left out of the reset branch so a reset leaves them alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        state_reg.tmr[i].cfg <= '0;
        state_reg.tmr[i].arm <= 1'b0;
        state_reg.tmr[i].tog_ff <= 1'b0;
        state_reg.tmr[i].gate_val <= 1'b0;
        state_reg.tmr[i].spm_open <= 1'b0;
        state_reg.tmr[i].roll_flag <= 1'b0;
        state_reg.tmr[i].gate_flag <= 1'b0;
        state_reg.tmr[i].cmp1_s <= 1'b0;
        state_reg.tmr[i].cmp2_s <= 1'b0;
        state_reg.tmr[i].src_prev <= 1'b0;
      end
      state_reg.bus <= '0;
    end else begin
      state_reg.bus <= state_next.bus;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        state_reg.tmr[i].cfg <= state_next.tmr[i].cfg;
        state_reg.tmr[i].arm <= state_next.tmr[i].arm;
        state_reg.tmr[i].tog_ff <= state_next.tmr[i].tog_ff;
        state_reg.tmr[i].gate_val <= state_next.tmr[i].gate_val;
        state_reg.tmr[i].spm_open <= state_next.tmr[i].spm_open;
        state_reg.tmr[i].roll_flag <= state_next.tmr[i].roll_flag;
        state_reg.tmr[i].gate_flag <= state_next.tmr[i].gate_flag;
        state_reg.tmr[i].cmp1_s <= state_next.tmr[i].cmp1_s;
        state_reg.tmr[i].cmp2_s <= state_next.tmr[i].cmp2_s;
        state_reg.tmr[i].src_prev <= state_next.tmr[i].src_prev;
        state_reg.tmr[i].count <= state_next.tmr[i].count;
      end
    end
  end

  // ****************************************************************
  // Outputs straight from flip-flops
  // ****************************************************************
  assign prdata = state_reg.bus.prdata;
  assign pready = state_reg.bus.pready;
  assign pslverr = state_reg.bus.pslverr;
  generate
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_flags
      assign rollover_flag[g] = state_reg.tmr[g].roll_flag;
      assign gate_event_flag[g] = state_reg.tmr[g].gate_flag;
    end
  endgenerate

  // ****************************************************************
  // Checks on every timer and on the bus handshake
  // ****************************************************************
  // Looping over all timers so whichever one a test drives is watched
  generate
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_chk
      chk_gate_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg.tmr[g].cfg.run && state_reg.tmr[g].cfg.gate_en && !state_reg.tmr[g].gate_val
        && !(psel && !penable && pwrite) |=> $stable(state_reg.tmr[g].count))
        else $error("Counter moved with gate closed");
      chk_off_stops: assert property (@(posedge pclk) disable iff (!presetn)
        !state_reg.tmr[g].cfg.run && !(psel && !penable && pwrite) |=> $stable(state_reg.tmr[g].count))
        else $error("Counter moved while off");
      chk_free_run: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg.tmr[g].cfg.run && !state_reg.tmr[g].cfg.gate_en && !(psel && !penable && pwrite)
        |=> state_reg.tmr[g].count == $past(state_reg.tmr[g].count) + 16'h0001)
        else $error("Free run failed to increment");
      chk_toggle_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !state_reg.tmr[g].cfg.toggle_en |=> !state_reg.tmr[g].tog_ff)
        else $error("Toggle flop not held clear");
      chk_arm_drop: assert property (@(posedge pclk) disable iff (!presetn)
        !state_reg.tmr[g].cfg.spm_en |-> !state_reg.tmr[g].arm)
        else $error("Arm set without single pulse mode");
      chk_gate_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(state_reg.tmr[g].gate_val) |-> state_reg.tmr[g].gate_flag)
        else $error("Gate flag missed falling gate");
      chk_roll_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $past(state_reg.tmr[g].count) == 16'hffff && state_reg.tmr[g].count == 16'h0000 |-> rollover_flag[g])
        else $error("Rollover flag missed");
      chk_arm_clear: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(state_reg.tmr[g].spm_open) && state_reg.tmr[g].cfg.spm_en |-> !state_reg.tmr[g].arm)
        else $error("Arm bit not cleared at pulse end");
      cov_roll: cover property (@(posedge pclk) disable iff (!presetn) $rose(rollover_flag[g]));
      cov_gate_evt: cover property (@(posedge pclk) disable iff (!presetn) $rose(gate_event_flag[g]));
      cov_pulse: cover property (@(posedge pclk) disable iff (!presetn) $fell(state_reg.tmr[g].arm));
    end
  endgenerate
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("Ready not one cycle after setup");

endmodule

// ==== verif/gtm_src_model.sv ====
// Gate source model: pin, overflow and comparator levels for each timer
`timescale 1ns/1ps
module gtm_src_model (
  // Clock
  input wire logic pclk,
  // Requested levels per timer, {pin, overflow, comparator 1, comparator 2}
  input wire logic [2:0][3:0] lvl,
  input wire logic [1:0] sync_en,
  // Sources seen by the timers
  output gtm_pkg::gtm_src_t [2:0] gate_src
);
  // Start high so no gate edge fires while reset is released
  initial begin
    gate_src = {3{6'h3c}};
  end

  // Sources move just after the edge, as logic on the same clock would
  always @(posedge pclk) begin
    for (int i = 0; i < 3; i++) begin
      gate_src[i] <= {lvl[i], sync_en};
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the three gated timers
`timescale 1ns/1ps
`include "gtm_map.svh"
module tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  typedef struct packed {logic [3:0] lvl; logic [7:0] gc;} gtm_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  gtm_pkg::gtm_src_t [2:0] gate_src;
  logic [2:0] rollover_flag;
  logic [2:0] gate_event_flag;
  logic [2:0][3:0] lvl = {3{4'hf}};
  logic [1:0] sync_en = 2'h0;
  logic [31:0] rd;
  logic err;
  logic [15:0] cnt;
  int fails = 0;
  int compares = 0;
  // Source levels beside the gate control value they must read back
  gtm_row_t rows [8] = '{'{4'h8, 8'hc4}, '{4'h8, 8'h80}, '{4'h4, 8'hc5}, '{4'hb, 8'hc1},
                        '{4'h2, 8'hc6}, '{4'h2, 8'h82}, '{4'h1, 8'hc7}, '{4'he, 8'hc3}};

  always #2.5 pclk = ~pclk;

  gtm_src_model src_u (.pclk(pclk), .lvl(lvl), .sync_en(sync_en), .gate_src(gate_src));

  gtm_timers #(.NUM_TIMERS(3)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gate_src(gate_src), .rollover_flag(rollover_flag),
    .gate_event_flag(gate_event_flag));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] ad(input logic [7:0] t, input logic [7:0] off);
    return t * `GTM_STRIDE + off;
  endfunction

  task automatic wr(input logic [7:0] t, input logic [7:0] off, input logic [7:0] d);
    apb(1'b1, ad(t, off), {24'h0, d});
  endtask

  task automatic rdchk(input string nm, input logic [7:0] t, input logic [7:0] off, input logic [7:0] e);
    apb(1'b0, ad(t, off), 32'h0);
    chk(nm, rd, {24'h0, e});
  endtask

  task automatic setcnt(input logic [7:0] t, input logic [15:0] v);
    wr(t, `GTM_OFF_CNTL, v[7:0]);
    wr(t, `GTM_OFF_CNTH, v[15:8]);
  endtask

  task automatic rdcnt(input logic [7:0] t);
    apb(1'b0, ad(t, `GTM_OFF_CNTL), 32'h0);
    cnt[7:0] = rd[7:0];
    apb(1'b0, ad(t, `GTM_OFF_CNTH), 32'h0);
    cnt[15:8] = rd[7:0];
  endtask

  // One high pulse on a gate pin, long enough to pass the sampling stages
  task automatic pulse(input int t);
    lvl[t] <= 4'h8;
    repeat (4) @(posedge pclk);
    lvl[t] <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #100us;
    fails++;
    test_done();
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Source select and polarity; the written status bit is flipped and must be ignored
    for (int i = 0; i < 8; i++) begin
      lvl[0] <= rows[i].lvl;
      sync_en <= 2'(i);
      wr(0, `GTM_OFF_GCTL, rows[i].gc ^ 8'h04);
      repeat (4) @(posedge pclk);
      rdchk("gate_control", 0, `GTM_OFF_GCTL, rows[i].gc);
    end
    // Unmapped offset and timer index past the last
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 8'h60, 32'hff);
    chk("bad timer err", {31'h0, err}, 32'h1);
    // Gate closed holds the count, gate off counts freely
    lvl[1] <= 4'h0;
    setcnt(1, 16'h1234);
    wr(1, `GTM_OFF_GCTL, 8'hc0);
    wr(1, `GTM_OFF_RUN, 8'h01);
    repeat (10) @(posedge pclk);
    wr(1, `GTM_OFF_RUN, 8'h00);
    rdcnt(1);
    chk("count gated", {16'h0, cnt}, 32'h1234);
    wr(1, `GTM_OFF_GCTL, 8'h40);
    wr(1, `GTM_OFF_RUN, 8'h01);
    repeat (10) @(posedge pclk);
    wr(1, `GTM_OFF_RUN, 8'h00);
    rdcnt(1);
    chk("count free", {31'h0, (cnt - 16'h1240) > 16'h1}, 32'h0);
    wr(1, `GTM_OFF_CNTL, 8'hab);
    rdcnt(1);
    chk("low byte write", {16'h0, cnt}, 32'h12ab);
    // Rollover on the third timer alone
    setcnt(2, 16'hfffe);
    wr(2, `GTM_OFF_RUN, 8'h01);
    repeat (4) @(posedge pclk);
    wr(2, `GTM_OFF_RUN, 8'h00);
    chk("rollover pins", {29'h0, rollover_flag}, 32'h4);
    rdchk("flags", 2, `GTM_OFF_FLAGS, 8'h01);
    rdcnt(2);
    chk("wrapped", {31'h0, cnt > 16'h0008}, 32'h0);
    wr(2, `GTM_OFF_FLAGS, 8'h01);
    rdchk("flags cleared", 2, `GTM_OFF_FLAGS, 8'h00);
    // Gate event with gate enable clear
    wr(1, `GTM_OFF_FLAGS, 8'h03);
    pulse(1);
    chk("gate event pin", {31'h0, gate_event_flag[1]}, 32'h1);
    rdchk("gate flags", 1, `GTM_OFF_FLAGS, 8'h02);
    // Toggle mode, cleared by stopping and by leaving the mode
    wr(1, `GTM_OFF_GCTL, 8'h60);
    wr(1, `GTM_OFF_RUN, 8'h01);
    pulse(1);
    rdchk("toggle high", 1, `GTM_OFF_GCTL, 8'h64);
    pulse(1);
    rdchk("toggle low", 1, `GTM_OFF_GCTL, 8'h60);
    pulse(1);
    wr(1, `GTM_OFF_RUN, 8'h00);
    repeat (3) @(posedge pclk);
    rdchk("toggle stop", 1, `GTM_OFF_GCTL, 8'h60);
    wr(1, `GTM_OFF_RUN, 8'h01);
    pulse(1);
    wr(1, `GTM_OFF_GCTL, 8'h40);
    repeat (3) @(posedge pclk);
    rdchk("toggle off", 1, `GTM_OFF_GCTL, 8'h40);
    // Single pulse: arm, complete, re-arm, leave the mode
    wr(1, `GTM_OFF_GCTL, 8'h58);
    rdchk("armed", 1, `GTM_OFF_GCTL, 8'h58);
    pulse(1);
    rdchk("pulse done", 1, `GTM_OFF_GCTL, 8'h50);
    wr(1, `GTM_OFF_GCTL, 8'h58);
    wr(1, `GTM_OFF_GCTL, 8'h48);
    rdchk("mode off", 1, `GTM_OFF_GCTL, 8'h40);
    // Mid-run reset: controls and flags clear, count kept
    wr(1, `GTM_OFF_RUN, 8'h00);
    setcnt(1, 16'hbeef);
    lvl <= {3{4'hf}};
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int t = 0; t < 3; t++) begin
      rdchk("reset run", 8'(t), `GTM_OFF_RUN, 8'h00);
      rdchk("reset gctl", 8'(t), `GTM_OFF_GCTL, 8'h00);
      rdchk("reset flags", 8'(t), `GTM_OFF_FLAGS, 8'h00);
    end
    rdcnt(1);
    chk("count kept", {16'h0, cnt}, 32'hbeef);
    test_done();
  end
endmodule
